// File: hdl/card_file_select_access.sv
/*
 * File navigation and access gating of a subscriber card: current directory,
 * current elementary file, cyclic record pointer and holder-code session rights.
 * Assumes commands arrive from logic on mclk, one at a time under cmd_ready.
 */
// Notes on behaviour
// - Full cyclic file overwrites its oldest record.
// - Record one follows record n, and back.
// - Newest record is number one, oldest n.
// - Cyclic updates use previous mode only.
// - Selecting cyclic file points at newest record.
// - Aborted action leaves record pointer unchanged.
// - At most 255 records of 255 bytes.
// - Session start selects the root directory.
// - Directory select clears the current elementary file.
// - File select keeps its parent as directory.
// - Application command runs only in its directory.
// - Only nearby files may be selected.
// - Selection by identifier, directory before its files.
// - Check the selected file's level before acting.
// - Read equals seek; select, status always allowed.
// - Level codes: open, one, two, reserved, operator, never.
// - Code one met by verify or unblock; disabled sets code_met only, not access.
// - Code two met only by verify or unblock.
// - Never level refused over the card interface.
// - Levels independent; one code grants no other.
// - Rights last the session; three wrong revoke.
// - Uninitialised code two refuses its commands.
// - Two-byte identifiers, first byte gives the type.
`default_nettype none
module card_file_select_access
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic session_start,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [2:0] cmd_op,
	input wire logic [15:0] cmd_fid,
	input wire logic [15:0] cmd_parent_fid,
	input wire logic [15:0] cmd_dir_fid,
	input wire logic [1:0] cmd_mode,
	input wire logic [7:0] cmd_rec,
	input wire logic hdr_cyclic,
	input wire logic [7:0] hdr_rec_count,
	input wire logic [7:0] hdr_newest,
	input wire logic [3:0] hdr_lvl_read,
	input wire logic [3:0] hdr_lvl_update,
	input wire logic [3:0] hdr_lvl_increase,
	input wire logic act_done,
	input wire logic act_abort,
	input wire logic [1:0] code_verify_ok,
	input wire logic [1:0] code_verify_bad,
	input wire logic [1:0] code_unblock_ok,
	input wire logic code_one_disabled,
	input wire logic code_two_init,
	input wire logic operator_ok,
	output logic rsp_valid,
	output logic [2:0] rsp_code,
	output logic [7:0] rsp_rec_addr,
	output logic [15:0] cur_dir_fid,
	output logic [15:0] cur_ef_fid,
	output logic ef_valid,
	output logic [7:0] ptr_rec,
	output logic [7:0] newest_rec,
	output logic [1:0] code_met
);
	////////////////////////////////////////////////////////////////////////////
	// Declarations.
	typedef enum logic [0:0] {ST_IDLE, ST_PEND} state_t; // Command sequencer states.
	state_t state_q; // Idle, or holding a pointer move open for abort.
	logic [15:0] path_q [0:2]; // Directory path from root down to the current one.
	logic [1:0] depth_q; // Depth of the current directory.
	logic [15:0] ef_q; // Current elementary file identifier.
	logic ef_valid_q; // A current elementary file exists.
	logic cyclic_q; // Current elementary file is cyclic.
	logic [3:0] lvl_read_q; // Read and seek level of the current file.
	logic [3:0] lvl_update_q; // Update level of the current file.
	logic [3:0] lvl_increase_q; // Increase level of the current file.
	logic [1:0] met_q; // Session rights per holder code.
	logic [1:0] wrong_q [0:1]; // Consecutive wrong attempts per holder code.
	logic rsp_valid_q; // Response strobe.
	logic [2:0] rsp_code_q; // Response code.
	logic [7:0] rsp_rec_q; // Physical record of the last record action.
	logic take; // A command is taken this cycle.
	logic [1:0] tdepth; // Directory depth implied by the target type.
	logic t_is_dir; // Target is the root or a directory.
	logic t_known; // Target type byte is recognised.
	logic sel_ok; // Target is reachable from here.
	logic [3:0] lvl; // Level that governs the command.
	logic granted; // Level is satisfied.
	logic rec_op; // Command moves through cyclic records.
	logic [2:0] code_d; // Response code for the command.
	logic [15:0] cur_dir; // Current directory identifier.
	logic [15:0] up_dir; // Parent of the current directory.
	logic [7:0] target_phys; // Record slot the step addresses.
	logic [7:0] count_shadow_q; // Record count of the current cyclic file.

	assign take = cmd_valid && cmd_ready;
	assign cmd_ready = (state_q == ST_IDLE);
	assign cur_dir = path_q[depth_q];
	assign up_dir = (depth_q == 2'h0) ? path_q[0] : path_q[depth_q - 2'h1];

	////////////////////////////////////////////////////////////////////////////
	// Selection and command checks.

	// The type byte tells whether the target is a directory and how deep.
	always_comb
	begin
		t_known = 1'b1;
		t_is_dir = 1'b1;
		case (cmd_fid[15:8])
			card_fs_pkg::TYPE_ROOT: tdepth = 2'h0;
			card_fs_pkg::TYPE_DIR1: tdepth = 2'h1;
			card_fs_pkg::TYPE_DIR2: tdepth = 2'h2;
			card_fs_pkg::TYPE_EF0: tdepth = 2'h0;
			card_fs_pkg::TYPE_EF1: tdepth = 2'h1;
			card_fs_pkg::TYPE_EF2: tdepth = 2'h2;
			default: tdepth = 2'h0;
		endcase
		if (cmd_fid[15:8] == card_fs_pkg::TYPE_EF0 || cmd_fid[15:8] == card_fs_pkg::TYPE_EF1
			|| cmd_fid[15:8] == card_fs_pkg::TYPE_EF2)
			t_is_dir = 1'b0;
		else if (cmd_fid[15:8] != card_fs_pkg::TYPE_ROOT && cmd_fid[15:8] != card_fs_pkg::TYPE_DIR1
			&& cmd_fid[15:8] != card_fs_pkg::TYPE_DIR2)
			t_known = 1'b0;
		// Root, itself, last selected file, parent, child or sibling directory.
		sel_ok = t_known && ((cmd_fid == card_fs_pkg::ROOT_FID)
			|| (cmd_fid == cur_dir)
			|| (ef_valid_q && cmd_fid == ef_q)
			|| (depth_q != 2'h0 && cmd_fid == up_dir)
			|| (cmd_parent_fid == cur_dir && (t_is_dir ? tdepth == depth_q + 2'h1 : tdepth == depth_q))
			|| (t_is_dir && depth_q != 2'h0 && tdepth == depth_q && cmd_parent_fid == up_dir));
	end

	// Pick the level of the last selected file that governs the command.
	always_comb
	begin
		case (cmd_op)
			card_fs_pkg::OP_READ: lvl = lvl_read_q;
			card_fs_pkg::OP_SEEK: lvl = lvl_read_q;
			card_fs_pkg::OP_UPDATE: lvl = lvl_update_q;
			card_fs_pkg::OP_INCREASE: lvl = lvl_increase_q;
			default: lvl = card_fs_pkg::LVL_ALWAYS;
		endcase
	end

	access_check u_access_check
	(
		.level(lvl),
		.code_one_met(met_q[0]),
		.code_two_met(met_q[1]),
		.operator_ok(operator_ok),
		.granted(granted)
	);

	// Response code, with the first failing check taking priority.
	always_comb
	begin
		code_d = card_fs_pkg::RSP_OK;
		rec_op = 1'b0;
		case (cmd_op)
			card_fs_pkg::OP_SELECT:
				code_d = sel_ok ? card_fs_pkg::RSP_OK : card_fs_pkg::RSP_BAD_TARGET;
			card_fs_pkg::OP_STATUS:
				code_d = card_fs_pkg::RSP_OK;
			card_fs_pkg::OP_APP:
				code_d = (cmd_dir_fid == cur_dir) ? card_fs_pkg::RSP_OK : card_fs_pkg::RSP_WRONG_DIR;
			card_fs_pkg::OP_CODE_TWO:
				code_d = code_two_init ? card_fs_pkg::RSP_OK : card_fs_pkg::RSP_NOT_INIT;
			default:
			begin
				if (!ef_valid_q)
					code_d = card_fs_pkg::RSP_NO_EF;
				else if (!granted)
					code_d = card_fs_pkg::RSP_DENIED;
				else if (cyclic_q && cmd_op == card_fs_pkg::OP_UPDATE && cmd_mode != card_fs_pkg::MODE_PREVIOUS)
					code_d = card_fs_pkg::RSP_BAD_MODE;
				else if (cyclic_q && cmd_op == card_fs_pkg::OP_READ && cmd_mode == card_fs_pkg::MODE_ABSOLUTE
					&& (cmd_rec == 8'h00 || cmd_rec > count_shadow_q))
					code_d = card_fs_pkg::RSP_BAD_MODE;
				rec_op = cyclic_q && (cmd_op == card_fs_pkg::OP_READ || cmd_op == card_fs_pkg::OP_UPDATE
					|| cmd_op == card_fs_pkg::OP_INCREASE);
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Directory path and current elementary file.

	// Session start returns to the root; selections move along the tree.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			path_q[0] <= card_fs_pkg::ROOT_FID;
			path_q[1] <= card_fs_pkg::FID_RESET;
			path_q[2] <= card_fs_pkg::FID_RESET;
			depth_q <= card_fs_pkg::DEPTH_RESET;
			ef_q <= card_fs_pkg::FID_RESET;
			ef_valid_q <= 1'b0;
		end
		else if (session_start)
		begin
			depth_q <= card_fs_pkg::DEPTH_RESET;
			ef_valid_q <= 1'b0;
		end
		else if (take && cmd_op == card_fs_pkg::OP_SELECT && sel_ok)
		begin
			if (t_is_dir)
			begin
				path_q[tdepth] <= cmd_fid;
				depth_q <= tdepth;
				ef_valid_q <= 1'b0;
			end
			else
			begin
				ef_q <= cmd_fid;
				ef_valid_q <= 1'b1;
			end
		end
	end

	// Header of the selected elementary file is latched at selection.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cyclic_q <= 1'b0;
			lvl_read_q <= card_fs_pkg::LVL_NEVER;
			lvl_update_q <= card_fs_pkg::LVL_NEVER;
			lvl_increase_q <= card_fs_pkg::LVL_NEVER;
			count_shadow_q <= card_fs_pkg::REC_RESET;
		end
		else if (take && cmd_op == card_fs_pkg::OP_SELECT && sel_ok && !t_is_dir)
		begin
			cyclic_q <= hdr_cyclic;
			lvl_read_q <= hdr_lvl_read;
			lvl_update_q <= hdr_lvl_update;
			lvl_increase_q <= hdr_lvl_increase;
			count_shadow_q <= hdr_rec_count;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Cyclic record pointer.

	cyclic_pointer u_cyclic_pointer
	(
		.mclk(mclk),
		.rst(rst),
		.load(take && cmd_op == card_fs_pkg::OP_SELECT && sel_ok && !t_is_dir && hdr_cyclic),
		.load_count(hdr_rec_count),
		.load_newest(hdr_newest),
		.step(take && rec_op && code_d == card_fs_pkg::RSP_OK),
		.step_write(cmd_op != card_fs_pkg::OP_READ),
		.step_mode(cmd_mode),
		.step_rec(cmd_rec),
		.restore(state_q == ST_PEND && act_abort),
		.ptr_q(ptr_rec),
		.newest_q(newest_rec),
		.target_phys(target_phys)
	);

	// A record move stays open until the action completes or aborts.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			state_q <= ST_IDLE;
		else
			case (state_q)
				ST_IDLE: if (take && rec_op && code_d == card_fs_pkg::RSP_OK)
					state_q <= ST_PEND;
				ST_PEND: if (act_done || act_abort)
					state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
	end

	// Response registers, one cycle after a command is taken.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rsp_valid_q <= 1'b0;
			rsp_code_q <= card_fs_pkg::RSP_OK;
			rsp_rec_q <= card_fs_pkg::REC_RESET;
		end
		else
		begin
			rsp_valid_q <= take;
			if (take)
				rsp_code_q <= code_d;
			// A refused record command is no action, so the last slot stands.
			if (take && rec_op && code_d == card_fs_pkg::RSP_OK)
				rsp_rec_q <= target_phys;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Holder-code session rights, one copy per code.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_code
			logic ok_in; // Successful verify or unblock of this code.
			assign ok_in = (code_verify_ok[gi] || code_unblock_ok[gi]) && (gi == 0 || code_two_init);
			// Wrong attempts survive session start; a success clears them.
			always_ff @(posedge mclk or posedge rst)
			begin
				if (rst)
				begin
					met_q[gi] <= 1'b0;
					wrong_q[gi] <= 2'h0;
				end
				else if (ok_in)
				begin
					met_q[gi] <= 1'b1;
					wrong_q[gi] <= 2'h0;
				end
				else
				begin
					// Session end and the third wrong attempt both clear; neither masks the other.
					if (session_start || (code_verify_bad[gi] && wrong_q[gi] + 2'h1 == card_fs_pkg::WRONG_LIMIT))
						met_q[gi] <= 1'b0;
					if (code_verify_bad[gi] && wrong_q[gi] != card_fs_pkg::WRONG_LIMIT)
						wrong_q[gi] <= wrong_q[gi] + 2'h1;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign code_met = {met_q[1], met_q[0] || code_one_disabled};
	assign rsp_valid = rsp_valid_q;
	assign rsp_code = rsp_code_q;
	assign rsp_rec_addr = rsp_rec_q;
	assign cur_dir_fid = cur_dir;
	assign cur_ef_fid = ef_q;
	assign ef_valid = ef_valid_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_pend_abort;
		state_q == ST_PEND && act_abort;
	endsequence

	root_after_start_a: assert property (@(posedge mclk) disable iff (rst)
		session_start |=> cur_dir_fid == card_fs_pkg::ROOT_FID && !ef_valid)
		else $error("session start did not select the root");
	dir_clears_ef_a: assert property (@(posedge mclk) disable iff (rst)
		take && !session_start && cmd_op == card_fs_pkg::OP_SELECT && sel_ok && t_is_dir |=> !ef_valid)
		else $error("directory select left a current file");
	ef_select_a: assert property (@(posedge mclk) disable iff (rst)
		take && !session_start && cmd_op == card_fs_pkg::OP_SELECT && sel_ok && !t_is_dir
		|=> ef_valid && cur_ef_fid == $past(cmd_fid) && cur_dir_fid == $past(cur_dir))
		else $error("file select did not keep its parent directory");
	app_dir_a: assert property (@(posedge mclk) disable iff (rst)
		take && cmd_op == card_fs_pkg::OP_APP && cmd_dir_fid != cur_dir |=> rsp_code == card_fs_pkg::RSP_WRONG_DIR)
		else $error("foreign application command accepted");
	never_refused_a: assert property (@(posedge mclk) disable iff (rst)
		take && ef_valid_q && cmd_op == card_fs_pkg::OP_READ && lvl_read_q == card_fs_pkg::LVL_NEVER
		|=> rsp_valid && rsp_code == card_fs_pkg::RSP_DENIED)
		else $error("never level read was not refused");
	cyclic_mode_a: assert property (@(posedge mclk) disable iff (rst)
		take && ef_valid_q && cyclic_q && granted && cmd_op == card_fs_pkg::OP_UPDATE
		&& cmd_mode != card_fs_pkg::MODE_PREVIOUS |=> rsp_code == card_fs_pkg::RSP_BAD_MODE)
		else $error("cyclic update in a mode other than previous");
	abort_restore_a: assert property (@(posedge mclk) disable iff (rst)
		(take && rec_op && code_d == card_fs_pkg::RSP_OK) ##1 s_pend_abort |=> ptr_rec == $past(ptr_rec, 2))
		else $error("abort did not restore the record pointer");
	status_always_a: assert property (@(posedge mclk) disable iff (rst)
		take && cmd_op == card_fs_pkg::OP_STATUS |=> rsp_code == card_fs_pkg::RSP_OK)
		else $error("status refused");
	revoke_a: assert property (@(posedge mclk) disable iff (rst)
		code_verify_bad[1] && !code_verify_ok[1] && !code_unblock_ok[1] && wrong_q[1] == 2'h2 |=> !code_met[1])
		else $error("third wrong attempt kept code two rights");
endmodule : card_file_select_access
`default_nettype wire

// File: pkg/card_fs_pkg.sv
/*
 * Shared constants for the card file navigation and access gating logic.
 * Assumes a single card clock; all users refer to names as card_fs_pkg::name.
 */
`default_nettype none
package card_fs_pkg;
	// File type bytes held in the upper byte of a file identifier.
	localparam logic [7:0] TYPE_ROOT = 8'h3f;
	localparam logic [7:0] TYPE_DIR1 = 8'h7f;
	localparam logic [7:0] TYPE_DIR2 = 8'h5f;
	localparam logic [7:0] TYPE_EF0 = 8'h2f;
	localparam logic [7:0] TYPE_EF1 = 8'h6f;
	localparam logic [7:0] TYPE_EF2 = 8'h4f;
	// Identifier of the root directory.
	localparam logic [15:0] ROOT_FID = 16'h3f00;
	// Values after reset.
	localparam logic [15:0] FID_RESET = 16'h0000;
	localparam logic [7:0] REC_RESET = 8'h01;
	localparam logic [1:0] DEPTH_RESET = 2'h0;
	// Consecutive wrong attempts that revoke a holder code.
	localparam logic [1:0] WRONG_LIMIT = 2'h3;
	// Access level codes.
	localparam logic [3:0] LVL_ALWAYS = 4'h0;
	localparam logic [3:0] LVL_CODE_ONE = 4'h1;
	localparam logic [3:0] LVL_CODE_TWO = 4'h2;
	localparam logic [3:0] LVL_RESERVED = 4'h3;
	localparam logic [3:0] LVL_NEVER = 4'hf;
	// Command operations.
	localparam logic [2:0] OP_SELECT = 3'h0;
	localparam logic [2:0] OP_STATUS = 3'h1;
	localparam logic [2:0] OP_READ = 3'h2;
	localparam logic [2:0] OP_UPDATE = 3'h3;
	localparam logic [2:0] OP_SEEK = 3'h4;
	localparam logic [2:0] OP_INCREASE = 3'h5;
	localparam logic [2:0] OP_APP = 3'h6;
	localparam logic [2:0] OP_CODE_TWO = 3'h7;
	// Record addressing modes.
	localparam logic [1:0] MODE_CURRENT = 2'h0;
	localparam logic [1:0] MODE_ABSOLUTE = 2'h1;
	localparam logic [1:0] MODE_NEXT = 2'h2;
	localparam logic [1:0] MODE_PREVIOUS = 2'h3;
	// Response codes.
	localparam logic [2:0] RSP_OK = 3'h0;
	localparam logic [2:0] RSP_BAD_TARGET = 3'h1;
	localparam logic [2:0] RSP_DENIED = 3'h2;
	localparam logic [2:0] RSP_NO_EF = 3'h3;
	localparam logic [2:0] RSP_BAD_MODE = 3'h4;
	localparam logic [2:0] RSP_WRONG_DIR = 3'h5;
	localparam logic [2:0] RSP_NOT_INIT = 3'h6;
endpackage : card_fs_pkg
`default_nettype wire

// File: hdl/access_check.sv
/*
 * Combinational decode of one four-bit access level against session rights.
 * Assumes the caller supplies the level of the last selected file.
 */
`default_nettype none
module access_check
(
	input wire logic [3:0] level,
	input wire logic code_one_met,
	input wire logic code_two_met,
	input wire logic operator_ok,
	output logic granted
);
	// Each level is decoded on its own; no level implies another.
	always_comb
	begin
		granted = 1'b0;
		if (level == card_fs_pkg::LVL_ALWAYS)
			granted = 1'b1;
		else if (level == card_fs_pkg::LVL_CODE_ONE)
			granted = code_one_met;
		else if (level == card_fs_pkg::LVL_CODE_TWO)
			granted = code_two_met;
		else if (level == card_fs_pkg::LVL_RESERVED)
			granted = 1'b0;
		else if (level != card_fs_pkg::LVL_NEVER)
			granted = operator_ok;
		else
			granted = 1'b0;
	end
endmodule : access_check
`default_nettype wire

// File: hdl/cyclic_pointer.sv
/*
 * Record pointer of the selected cyclic file, kept as a record number by age.
 * Assumes step, load and restore are single-cycle pulses on mclk.
 */
`default_nettype none
module cyclic_pointer
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic load,
	input wire logic [7:0] load_count,
	input wire logic [7:0] load_newest,
	input wire logic step,
	input wire logic step_write,
	input wire logic [1:0] step_mode,
	input wire logic [7:0] step_rec,
	input wire logic restore,
	output logic [7:0] ptr_q,
	output logic [7:0] newest_q,
	output logic [7:0] target_phys
);
	logic [7:0] count_q; // Records in the file, 1 to 255.
	logic [7:0] save_ptr_q; // Pointer before the last step.
	logic [7:0] save_newest_q; // Newest slot before the last step.
	logic [7:0] succ; // Successor of the pointer.
	logic [7:0] pred; // Predecessor of the pointer.
	logic [7:0] target; // Record number the step addresses.
	logic [8:0] sum; // Physical slot before wrapping.

	// Neighbours wrap between the last and the first record.
	always_comb
	begin
		succ = (ptr_q == count_q) ? 8'h01 : ptr_q + 8'h01;
		pred = (ptr_q == 8'h01) ? count_q : ptr_q - 8'h01;
		case (step_mode)
			card_fs_pkg::MODE_ABSOLUTE: target = step_rec;
			card_fs_pkg::MODE_NEXT: target = succ;
			card_fs_pkg::MODE_PREVIOUS: target = pred;
			default: target = ptr_q;
		endcase
		if (step_write)
			target = count_q;
		sum = {1'b0, newest_q} + {1'b0, target} - 9'h001;
		if (sum > {1'b0, count_q})
			sum = sum - {1'b0, count_q};
		target_phys = sum[7:0];
	end

	// Pointer, newest slot and the copies used to undo an aborted action.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ptr_q <= card_fs_pkg::REC_RESET;
			newest_q <= card_fs_pkg::REC_RESET;
			count_q <= card_fs_pkg::REC_RESET;
			save_ptr_q <= card_fs_pkg::REC_RESET;
			save_newest_q <= card_fs_pkg::REC_RESET;
		end
		else if (load)
		begin
			ptr_q <= card_fs_pkg::REC_RESET;
			newest_q <= load_newest;
			count_q <= load_count;
		end
		else if (restore)
		begin
			ptr_q <= save_ptr_q;
			newest_q <= save_newest_q;
		end
		else if (step)
		begin
			save_ptr_q <= ptr_q;
			save_newest_q <= newest_q;
			ptr_q <= step_write ? card_fs_pkg::REC_RESET : target;
			if (step_write)
				newest_q <= target_phys;
		end
	end

	select_ptr_a: assert property (@(posedge mclk) disable iff (rst) load |=> ptr_q == 8'h01)
		else $error("pointer not at newest record after select");
	wrap_next_a: assert property (@(posedge mclk) disable iff (rst)
		step && !step_write && !load && !restore && step_mode == card_fs_pkg::MODE_NEXT && ptr_q == count_q
		|=> ptr_q == 8'h01)
		else $error("next from last record did not wrap to first");
	write_oldest_a: assert property (@(posedge mclk) disable iff (rst)
		step && step_write && !load && !restore
		|=> ptr_q == 8'h01 && newest_q == $past(target_phys))
		else $error("cyclic write did not take the oldest slot");
endmodule : cyclic_pointer
`default_nettype wire

// File: bench/terminal_model.sv
/* Terminal side model that finishes or aborts each pending record move.
 * Assumes cmd_ready low marks a pending move and inputs change on falling edges. */
`default_nettype none
module terminal_model
(
	input wire logic mclk,
	input wire logic cmd_ready,
	input wire logic abort_next,
	input wire logic [1:0] lag,
	output logic act_done = 1'b0,
	output logic act_abort = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] wait_q = 3'h0; // Cycles waited on the pending move.
	// Ends a pending move after lag cycles with a one-cycle pulse.
	always @(negedge mclk)
	begin
		act_done <= 1'b0;
		act_abort <= 1'b0;
		if (!cmd_ready && !act_done && !act_abort)
		begin
			if (wait_q >= {1'b0, lag})
			begin
				act_done <= !abort_next;
				act_abort <= abort_next;
				wait_q <= 3'h0;
			end
			else
				wait_q <= wait_q + 3'h1;
		end
	end
endmodule : terminal_model
`default_nettype wire

// File: bench/tb_top.sv
/* Self-checking bench of the card file selection and access block.
 * Assumes terminal_model completes the record moves that the block holds. */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, rst = 1'b1, session_start = 1'b0, cmd_valid = 1'b0, cmd_ready, hdr_cyclic = 1'b1;
	logic act_done, act_abort, code_one_disabled = 1'b0, code_two_init = 1'b0, operator_ok = 1'b0;
	logic rsp_valid, ef_valid, abort_next = 1'b0;
	logic [2:0] cmd_op = 3'h0, rsp_code;
	logic [15:0] cmd_fid = 16'h0, cmd_parent_fid = 16'h0, cmd_dir_fid = 16'h0, cur_dir_fid, cur_ef_fid;
	logic [1:0] cmd_mode = 2'h0, code_verify_ok = 2'h0, code_verify_bad = 2'h0, code_unblock_ok = 2'h0;
	logic [1:0] code_met, lag = 2'h0;
	logic [7:0] cmd_rec = 8'h0, hdr_rec_count = 8'h4, hdr_newest = 8'h2, rsp_rec_addr, ptr_rec, newest_rec;
	logic [3:0] hdr_lvl_read = 4'h1, hdr_lvl_update = 4'h2, hdr_lvl_increase = 4'hf;
	int failures = 0, n_compared = 0;
	card_file_select_access uut (.mclk, .rst, .session_start, .cmd_valid, .cmd_ready, .cmd_op, .cmd_fid,
		.cmd_parent_fid, .cmd_dir_fid, .cmd_mode, .cmd_rec, .hdr_cyclic, .hdr_rec_count, .hdr_newest,
		.hdr_lvl_read, .hdr_lvl_update, .hdr_lvl_increase, .act_done, .act_abort, .code_verify_ok,
		.code_verify_bad, .code_unblock_ok, .code_one_disabled, .code_two_init, .operator_ok, .rsp_valid,
		.rsp_code, .rsp_rec_addr, .cur_dir_fid, .cur_ef_fid, .ef_valid, .ptr_rec, .newest_rec, .code_met);
	terminal_model partner (.mclk, .cmd_ready, .abort_next, .lag, .act_done, .act_abort);
	initial forever #4 mclk = ~mclk;
	// Compares one value and counts it.
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	// Lets one edge pass so cmd_valid drops between commands, then waits, bounded, for no pending move.
	task automatic idle();
		@(negedge mclk);
		for (int i = 0; i < 20 && cmd_ready !== 1'b1; i++)
			@(negedge mclk);
	endtask : idle
	// Issues one command and checks the one-cycle response.
	task automatic cmd(input logic [2:0] op, input logic [1:0] mode, input logic [2:0] exp);
		idle();
		cmd_op = op;
		cmd_mode = mode;
		cmd_valid = 1'b1;
		@(negedge mclk);
		cmd_valid = 1'b0;
		check("rsp_valid", {15'h0, rsp_valid}, 16'h1);
		check("rsp_code", {13'h0, rsp_code}, {13'h0, exp});
	endtask : cmd
	task automatic sel(input logic [15:0] fid, input logic [15:0] par, input logic [2:0] exp);
		cmd_fid = fid;
		cmd_parent_fid = par;
		cmd(card_fs_pkg::OP_SELECT, 2'h0, exp);
	endtask : sel
	// Pulses session code events for one cycle.
	task automatic pulse(input logic [1:0] ok, input logic [1:0] bad);
		code_verify_ok = ok;
		code_verify_bad = bad;
		@(negedge mclk);
		code_verify_ok = 2'h0;
		code_verify_bad = 2'h0;
		@(negedge mclk);
	endtask : pulse
	// Main sequence of command scenarios.
	initial
	begin
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		session_start = 1'b1;
		@(negedge mclk);
		session_start = 1'b0;
		@(negedge mclk);
		check("dir", cur_dir_fid, 16'h3f00);
		check("ef_valid", {15'h0, ef_valid}, 16'h0);
		sel(16'h7f20, 16'h3f00, card_fs_pkg::RSP_OK);
		check("dir", cur_dir_fid, 16'h7f20);
		sel(16'h5f30, 16'h7f10, card_fs_pkg::RSP_BAD_TARGET);
		check("dir", cur_dir_fid, 16'h7f20);
		sel(16'h6f40, 16'h7f20, card_fs_pkg::RSP_OK);
		check("ef", cur_ef_fid, 16'h6f40);
		check("ptr", {8'h0, ptr_rec}, 16'h1);
		check("newest", {8'h0, newest_rec}, 16'h2);
		cmd(card_fs_pkg::OP_READ, card_fs_pkg::MODE_CURRENT, card_fs_pkg::RSP_DENIED);
		cmd(card_fs_pkg::OP_STATUS, 2'h0, card_fs_pkg::RSP_OK);
		cmd(card_fs_pkg::OP_CODE_TWO, 2'h0, card_fs_pkg::RSP_NOT_INIT);
		pulse(2'h1, 2'h0);
		check("met", {14'h0, code_met}, 16'h1);
		cmd(card_fs_pkg::OP_UPDATE, card_fs_pkg::MODE_PREVIOUS, card_fs_pkg::RSP_DENIED);
		cmd(card_fs_pkg::OP_INCREASE, 2'h0, card_fs_pkg::RSP_DENIED);
		code_two_init = 1'b1;
		pulse(2'h2, 2'h0);
		check("met", {14'h0, code_met}, 16'h3);
		cmd(card_fs_pkg::OP_UPDATE, card_fs_pkg::MODE_NEXT, card_fs_pkg::RSP_BAD_MODE);
		abort_next = 1'b1;
		cmd(card_fs_pkg::OP_UPDATE, card_fs_pkg::MODE_PREVIOUS, card_fs_pkg::RSP_OK);
		check("slot", {8'h0, rsp_rec_addr}, 16'h1);
		idle();
		check("newest", {8'h0, newest_rec}, 16'h2);
		abort_next = 1'b0;
		lag = 2'h2;
		cmd(card_fs_pkg::OP_UPDATE, card_fs_pkg::MODE_PREVIOUS, card_fs_pkg::RSP_OK);
		cmd(card_fs_pkg::OP_UPDATE, card_fs_pkg::MODE_PREVIOUS, card_fs_pkg::RSP_OK);
		idle();
		check("newest", {8'h0, newest_rec}, 16'h4);
		check("ptr", {8'h0, ptr_rec}, 16'h1);
		cmd(card_fs_pkg::OP_READ, card_fs_pkg::MODE_ABSOLUTE, card_fs_pkg::RSP_BAD_MODE);
		cmd_dir_fid = 16'h7f10;
		cmd(card_fs_pkg::OP_APP, 2'h0, card_fs_pkg::RSP_WRONG_DIR);
		hdr_lvl_read = 4'hf;
		sel(16'h6f40, 16'h7f20, card_fs_pkg::RSP_OK);
		cmd(card_fs_pkg::OP_READ, card_fs_pkg::MODE_CURRENT, card_fs_pkg::RSP_DENIED);
		hdr_lvl_read = 4'h5;
		sel(16'h6f40, 16'h7f20, card_fs_pkg::RSP_OK);
		cmd(card_fs_pkg::OP_SEEK, 2'h0, card_fs_pkg::RSP_DENIED);
		operator_ok = 1'b1;
		cmd(card_fs_pkg::OP_SEEK, 2'h0, card_fs_pkg::RSP_OK);
		repeat (3) pulse(2'h0, 2'h2);
		check("met", {14'h0, code_met}, 16'h1);
		give_verdict();
	end
	// Cuts a hang short.
	initial
	begin
		repeat (2000) @(posedge mclk);
		failures++;
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
